// ### src/agp_regs.sv
// agp_regs: configuration bank for the ratio, power mode and per-channel gain selects
// assumes an axi4-lite master on aclk, one write and one read outstanding at most
// Functional notes
// RQ1: three-bit ratio code selects 128..16256, default 1024
// RQ2: turbo bit forces ratio 64, ignores code
// RQ3: power mode field bits 1:0, reset high-res
// RQ4: channel 1 gain in bits 6:4
// RQ5: channel 0 gain in bits 2:0
// RQ6: gain word at index 4, resets zero
// RQ7: reserved word at index 5, resets zero
// RQ8: host writes zeros to reserved bits
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module agp_regs
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded configuration to the converter
  output logic [14:0] oversample_ratio,
  output agp_pkg::agp_pmode_t power_mode_sel,
  output logic [7:0] ch0_gain,
  output logic [7:0] ch1_gain
);
  logic [1:0] pmode_code_r;
  logic [2:0] ratio_code_r;
  logic turbo_r;
  logic [15:0] gain_config_r;
  logic [15:0] rsvd_r;
  logic aw_held_r;
  logic [5:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire logic wr_fire;
  wire logic [5:0] wr_addr;
  wire logic [31:0] wr_data;
  wire logic [3:0] wr_strb;
  wire logic [15:0] wr_mask;
  wire logic hit_clk;
  wire logic hit_gain;
  wire logic hit_rsvd;
  wire logic wr_hit;
  wire logic [15:0] clk_word;
  wire logic [15:0] clk_nxt;
  wire logic [15:0] gain_config_nxt;
  wire logic [15:0] rsvd_nxt;
  wire logic rd_fire;
  wire logic rd_hit;
  wire logic [15:0] rd_word;
  wire logic [1:0] pmode_code_nxt;
  wire logic [2:0] ratio_code_nxt;
  wire logic turbo_nxt;
  wire logic [15:0] gain_word_nxt;
  wire logic [14:0] ratio_dec;
  agp_pkg::agp_pmode_t pmode_dec;
  wire logic [7:0] ch0_dec;
  wire logic [7:0] ch1_dec;

  // address and data may arrive in either order; each is parked until both are in
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_r || (s_axi_wvalid && s_axi_wready));
  assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign hit_clk = wr_addr == agp_pkg::ADDR_CLK_CFG;
  assign hit_gain = wr_addr == agp_pkg::ADDR_GAIN_CFG;
  assign hit_rsvd = wr_addr == agp_pkg::ADDR_RSVD;
  assign wr_hit = hit_clk || hit_gain || hit_rsvd;

  // only the clock-config tail is held here; its other bits read as zero
  assign clk_word = {10'h000, turbo_r, ratio_code_r, pmode_code_r};
  assign clk_nxt = (clk_word & ~wr_mask) | (wr_data[15:0] & wr_mask);
  // reserved bits stored as written; host is expected to write zeros
  assign gain_config_nxt = (gain_config_r & ~wr_mask) | (wr_data[15:0] & wr_mask);
  assign rsvd_nxt = (rsvd_r & ~wr_mask) | (wr_data[15:0] & wr_mask);

  // what the bank holds after this edge; decoding it lets the flopped outputs move with the registers
  assign pmode_code_nxt = !aresetn ? agp_pkg::PMODE_RST :
                          (wr_fire && hit_clk) ? clk_nxt[agp_pkg::PMODE_LSB +: 2] : pmode_code_r; // [RQ3]
  assign ratio_code_nxt = !aresetn ? agp_pkg::RATIO_RST :
                          (wr_fire && hit_clk) ? clk_nxt[agp_pkg::RATIO_LSB +: 3] : ratio_code_r; // [RQ1]
  assign turbo_nxt = !aresetn ? agp_pkg::TURBO_RST :
                     (wr_fire && hit_clk) ? clk_nxt[agp_pkg::TURBO_BIT] : turbo_r; // [RQ2]
  assign gain_word_nxt = !aresetn ? agp_pkg::GAIN_RST :
                         (wr_fire && hit_gain) ? gain_config_nxt : gain_config_r; // [RQ6]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pmode_code_r <= agp_pkg::PMODE_RST; // [RQ3]
      ratio_code_r <= agp_pkg::RATIO_RST; // [RQ1]
      turbo_r <= agp_pkg::TURBO_RST; // [RQ2]
      gain_config_r <= agp_pkg::GAIN_RST; // [RQ6] [RQ4] [RQ5]
      rsvd_r <= agp_pkg::RSVD_RST; // [RQ7]
    end
    else if (wr_fire)
    begin
      if (hit_clk)
      begin
        pmode_code_r <= clk_nxt[agp_pkg::PMODE_LSB +: 2]; // [RQ3]
        ratio_code_r <= clk_nxt[agp_pkg::RATIO_LSB +: 3]; // [RQ1]
        turbo_r <= clk_nxt[agp_pkg::TURBO_BIT]; // [RQ2]
      end
      if (hit_gain)
        gain_config_r <= gain_config_nxt; // [RQ6]
      if (hit_rsvd)
        rsvd_r <= rsvd_nxt; // [RQ7]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= agp_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? agp_pkg::RESP_OKAY : agp_pkg::RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
          bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // read path: one read outstanding, answered the cycle after arvalid is taken
  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hit = (s_axi_araddr == agp_pkg::ADDR_CLK_CFG) || (s_axi_araddr == agp_pkg::ADDR_GAIN_CFG) ||
                  (s_axi_araddr == agp_pkg::ADDR_RSVD);
  assign rd_word = (s_axi_araddr == agp_pkg::ADDR_CLK_CFG) ? clk_word :
                   (s_axi_araddr == agp_pkg::ADDR_GAIN_CFG) ? gain_config_r :
                   (s_axi_araddr == agp_pkg::ADDR_RSVD) ? rsvd_r : 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= agp_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_word};
      rresp_r <= rd_hit ? agp_pkg::RESP_OKAY : agp_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // decoded settings leave through flops, so a field change never glitches into the converter
  // no reset branch needed: the next-state fields already carry the reset values
  always_ff @(posedge aclk)
  begin
    oversample_ratio <= ratio_dec; // [RQ1] [RQ2]
    power_mode_sel <= pmode_dec; // [RQ3]
    ch0_gain <= ch0_dec; // [RQ5]
    ch1_gain <= ch1_dec; // [RQ4]
  end

  agp_decode u_decode
  (
    .ratio_code(ratio_code_nxt),
    .turbo(turbo_nxt),
    .pmode_code(pmode_code_nxt),
    .ch0_code(gain_word_nxt[agp_pkg::CH0_GAIN_LSB +: 3]),
    .ch1_code(gain_word_nxt[agp_pkg::CH1_GAIN_LSB +: 3]),
    .oversample_ratio(ratio_dec),
    .pmode(pmode_dec),
    .ch0_gain(ch0_dec),
    .ch1_gain(ch1_dec)
  );
endmodule // agp_regs

// ### src/agp_pkg.sv
// agp_pkg: register map, field layout and reset values of the gain/power/ratio config bank
// assumes a 32-bit axi4-lite register bus, one aligned word per register
package agp_pkg;
  // printed offsets are register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CLK_CFG = 4'h3;
  localparam logic [3:0] IDX_GAIN_CFG = 4'h4;
  localparam logic [3:0] IDX_RSVD = 4'h5;
  localparam logic [5:0] ADDR_CLK_CFG = {IDX_CLK_CFG, 2'b00};
  localparam logic [5:0] ADDR_GAIN_CFG = {IDX_GAIN_CFG, 2'b00};
  localparam logic [5:0] ADDR_RSVD = {IDX_RSVD, 2'b00};

  // clock-config word fields
  localparam int PMODE_LSB = 0;
  localparam int RATIO_LSB = 2;
  localparam int TURBO_BIT = 5;
  // gain word fields
  localparam int CH0_GAIN_LSB = 0;
  localparam int CH1_GAIN_LSB = 4;

  localparam logic [1:0] PMODE_RST = 2'h2;
  localparam logic [2:0] RATIO_RST = 3'h3;
  localparam logic TURBO_RST = 1'b0;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] RSVD_RST = 16'h0000;

  localparam logic [14:0] TURBO_RATIO = 15'h0040;

  typedef enum logic [1:0]
  {
    PM_VLP = 2'h0,
    PM_LP = 2'h1,
    PM_HR = 2'h2
  } agp_pmode_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/agp_decode.sv
// agp_decode: turns the stored select fields into ratios, gains and a power mode
// assumes select fields arrive as the bank's next-state values, not from the register flops
`timescale 1ns/100ps
module agp_decode
(
  // stored fields
  input wire logic [2:0] ratio_code,
  input wire logic turbo,
  input wire logic [1:0] pmode_code,
  input wire logic [2:0] ch0_code,
  input wire logic [2:0] ch1_code,
  // decoded values
  output logic [14:0] oversample_ratio,
  output agp_pkg::agp_pmode_t pmode,
  output logic [7:0] ch0_gain,
  output logic [7:0] ch1_gain
);
  wire logic [14:0] ratio_table;

  // top code is 16256, not a power of two
  assign ratio_table = (ratio_code == 3'h7) ? 15'h3F80 : 15'(15'h0080 << ratio_code); // [RQ1]
  assign oversample_ratio = turbo ? agp_pkg::TURBO_RATIO : ratio_table; // [RQ2]
  assign pmode = (pmode_code == 2'h0) ? agp_pkg::PM_VLP :
                 (pmode_code == 2'h1) ? agp_pkg::PM_LP : agp_pkg::PM_HR; // [RQ3]
  assign ch0_gain = 8'(8'h01 << ch0_code); // [RQ5]
  assign ch1_gain = 8'(8'h01 << ch1_code); // [RQ4]
endmodule // agp_decode

// ### verification/agp_regs_sva.sv
// agp_regs_sva: port-level checks for the gain, power and osr config bank
// assumes it is bound to agp_regs and sees only that module's ports
`timescale 1ns/100ps
module agp_regs_sva
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded configuration
  input wire logic [14:0] oversample_ratio,
  input wire logic [1:0] power_mode_sel,
  input wire logic [7:0] ch0_gain,
  input wire logic [7:0] ch1_gain
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // decoded outputs may only move on the cycle a write completes
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  sequence s_rd_ans;
    ##1 s_axi_rvalid;
  endsequence
  sequence s_wr_ans;
    ##1 s_axi_bvalid;
  endsequence
  ratio_legal_a:
    assert property (($onehot(oversample_ratio) && oversample_ratio inside {[15'h0040:15'h2000]})
      || oversample_ratio == 15'h3F80)
    else $error("bad ratio");
  gain_onehot_a:
    assert property ($onehot(ch0_gain) && $onehot(ch1_gain)) else $error("bad gain");
  pmode_legal_a:
    assert property (power_mode_sel != 2'h3) else $error("bad mode");
  rst_value_a:
    assert property ($rose(aresetn) |-> oversample_ratio == 15'h0400 && power_mode_sel == agp_pkg::PM_HR
      && ch0_gain == 8'h01 && ch1_gain == 8'h01) else $error("bad reset value");
  cfg_change_a:
    assert property ($changed(oversample_ratio) || $changed(power_mode_sel) || $changed(ch0_gain) || $changed(ch1_gain)
      |-> s_wr_done) else $error("config moved without a write");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  r_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |-> s_rd_ans) else $error("late read answer");
  b_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> s_wr_ans)
      else $error("late write answer");
endmodule // agp_regs_sva

bind agp_regs agp_regs_sva u_sva (.*);

// ### verification/tb.sv
// tb: random and corner register traffic for agp_regs, self-checking
// assumes the bank answers only through its axi4-lite handshakes
`timescale 1ns/100ps
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ta, tw, tr;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [14:0] oversample_ratio;
  logic [7:0] ch0_gain, ch1_gain;
  agp_pkg::agp_pmode_t power_mode_sel;
  int err_count, check_count, i, n;
  localparam logic [1:0] OK = agp_pkg::RESP_OKAY;
  agp_regs u_dut (.*);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] ratio_e(input logic t, input logic [2:0] c);
    return t ? 32'h40 : (c == 3'h7 ? 32'h3F80 : 32'h80 << c);
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one transfer; sampling at the falling edge sees what the next rising edge will take
  task ax(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    // answer ready goes up with the request and stays until the answer is seen
    s_axi_bready <= w;
    s_axi_rready <= !w;
    tr = 1'b0;
    for (n = 0; n < 60 && !tr; n++)
    begin
      @(negedge aclk);
      ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = w ? s_axi_bvalid : s_axi_rvalid;
      v = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    if (!tr)
    begin
      err_count++;
      $display("wrong value at %0t: no answer", $time);
      tally_and_finish;
    end
    chk({30'h0, r}, {30'h0, e});
    if (!w)
      chk(v, d);
  endtask
  task rchk;
    ax(1'b0, agp_pkg::ADDR_CLK_CFG, 32'h0000000E, OK);
    ax(1'b0, agp_pkg::ADDR_GAIN_CFG, 32'h0, OK);
    ax(1'b0, agp_pkg::ADDR_RSVD, 32'h0, OK);
    chk({17'h0, oversample_ratio}, 32'h400);
    chk({8'h0, ch1_gain, 8'h0, ch0_gain}, 32'h00010001);
  endtask
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'hF;
    err_count = 0;
    check_count = 0;
    seed = 32'h92B9;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk;
    for (i = 0; i < 64; i++)
    begin
      seed = lfsr(seed);
      ax(1'b1, agp_pkg::ADDR_CLK_CFG, {seed[31:6], i[5:0]}, OK);
      ax(1'b0, agp_pkg::ADDR_CLK_CFG, {26'h0, i[5:0]}, OK);
      chk({17'h0, oversample_ratio}, ratio_e(i[5], i[4:2]));
      chk({30'h0, power_mode_sel}, {30'h0, i[1:0] == 2'h3 ? 2'h2 : i[1:0]});
    end
    for (i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      ax(1'b1, agp_pkg::ADDR_GAIN_CFG, {seed[31:16], 9'h0, i[2:0], 1'b0, seed[2:0]}, OK);
      ax(1'b0, agp_pkg::ADDR_GAIN_CFG, {25'h0, i[2:0], 1'b0, seed[2:0]}, OK);
      chk({24'h0, ch1_gain}, 32'h1 << i[2:0]);
      chk({24'h0, ch0_gain}, 32'h1 << seed[2:0]);
    end
    ax(1'b1, agp_pkg::ADDR_RSVD, 32'h0, OK);
    ax(1'b1, 6'h18, seed, agp_pkg::RESP_SLVERR);
    ax(1'b0, 6'h3C, 32'h0, agp_pkg::RESP_SLVERR);
    // upper-byte-only write must leave both gain fields alone
    s_axi_wstrb <= 4'h2;
    ax(1'b1, agp_pkg::ADDR_GAIN_CFG, 32'h0, OK);
    s_axi_wstrb <= 4'hF;
    ax(1'b0, agp_pkg::ADDR_GAIN_CFG, {25'h0, 3'h7, 1'b0, seed[2:0]}, OK);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk;
    tally_and_finish;
  end
endmodule // tb
